// [verilog/fpd_consts.svh]
// fpd_consts.svh: byte offsets, lengths and timing of the image mapper
// assumes it is included by its bare name from design files only
`ifndef FPD_CONSTS_SVH
`define FPD_CONSTS_SVH
// image lengths in bytes
`define FPD_LEN_BASIC 6'h06
`define FPD_LEN_EXT2 6'h0C
`define FPD_LEN_EXT1 6'h20
// output image word offsets, high byte first
`define FPD_O_OPCMD 6'h00
`define FPD_O_FREF 6'h02
`define FPD_O_AOUT 6'h0A
`define FPD_O_DOUT 6'h0E
// input image word offsets
`define FPD_I_STAT 6'h00
`define FPD_I_SPEED 6'h02
`define FPD_I_CUR_B 6'h04
`define FPD_I_TRQ 6'h04
`define FPD_I_FREF 6'h08
`define FPD_I_OFREQ 6'h0A
`define FPD_I_CUR_X 6'h0C
`define FPD_I_AIN 6'h0E
// message region bounds
`define FPD_MSG_EXT1 6'h10
`define FPD_MSG_EXT2 6'h04
`define FPD_RSV1_LO 6'h1C
`define FPD_RSV1_HI 6'h1E
`define FPD_RSV2 6'h0A
// map format value for the conventional layouts
`define FPD_FMT_CONV 1'b1
// current rescale from 0.01 A to 0.1 A
`define FPD_CUR_DIV 16'h000A
// fast command latency bound and clock period
`define FPD_FAST_LAT_NS 2000000
`define FPD_CLK_NS 50
`endif

// [verilog/fpd_pkg.sv]
// fpd_pkg: shared types of the process data image mapper
// assumes fpd_consts.svh carries the numeric constants
package fpd_pkg;
  // image length chosen by the master configuration
  typedef enum logic [1:0] {
    FPD_IMG_BASIC = 2'b00,
    FPD_IMG_EXT2 = 2'b01,
    FPD_IMG_EXT1 = 2'b10
  } fpd_img_t;
  // input image sender states
  typedef enum logic {
    FPD_TX_IDLE = 1'b0,
    FPD_TX_SEND = 1'b1
  } fpd_tx_t;
endpackage

// [verilog/fpd_fifo.sv]
// fpd_fifo: flop based first in first out buffer, valid/ready both sides
// assumes one clock and a synchronous active high reset
`timescale 1ns/10ps
`default_nettype none
module fpd_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("fpd_fifo: DEPTH must be a power of two >= 2");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic rdy_reg, rdy_next;
  logic push, pop;

  ////////////////////////////////////////////////////////////////////////
  // pointers and count; ready is a flop so the top can pass it out raw
  assign push = in_valid && rdy_reg;
  assign pop = out_valid && out_ready;
  always_comb begin
    wr_next = push ? AW'(wr_reg + 1'b1) : wr_reg;
    rd_next = pop ? AW'(rd_reg + 1'b1) : rd_reg;
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = (AW+1)'(cnt_reg + 1'b1);
    end else if (pop && !push) begin
      cnt_next = (AW+1)'(cnt_reg - 1'b1);
    end
    rdy_next = cnt_next != (AW+1)'(DEPTH);
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'b1;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      rdy_reg <= rdy_next;
    end
  end
  // storage has no reset; an unwritten entry can show on out_data only while out_valid is low
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end
  assign in_ready = rdy_reg;
  assign out_valid = cnt_reg != '0;
  assign out_data = mem_reg[rd_reg];
endmodule
`default_nettype wire

// [verilog/fpd_mapper.sv]
// fpd_mapper: maps the cyclic output and input byte images of a fieldbus
// slave card onto drive commands, monitors and a message byte stream.
// assumes bytes arrive and leave one per cycle with valid/ready, the
// drive side writes message replies by index, and map format and rating
// straps are steady around the release of reset.
// Notes on behaviour
// - fast data goes straight to drive; message bytes are forwarded
// - conventional layouts only when map format select is 1
// - run/stop and speed commands reach the drive well within 2 ms, except while a full message buffer holds off the frame end
// - message region reaches every drive parameter, not only fast ones
// - basic: fast 0-5; 32 byte: msg 16-31; 12 byte: msg 4-11
// - 16-bit items high byte first; command and status in bytes 0-1
// - frequency reference in output bytes 2-3; basic bytes 4-5 unused
// - basic input returns motor speed in 2-3, current in 4-5
// - current in 0.01 A on small ratings, 0.1 A on large ones
// - in V/f control the speed field carries output frequency
// - 32 byte output: analog out in 10-11, digital out in 14-15
// - 32 byte input: torque, freq ref, out freq, current, analog in
// - 32 byte message: code, address, count, four words, handshake 31
// - 12 byte message: code, address, length, one word, handshake 11
// - map format change takes effect only after a restart
`timescale 1ns/10ps
`default_nettype none
`include "fpd_consts.svh"
module fpd_mapper import fpd_pkg::*; #(
  parameter int FIFO_DEPTH = 16,
  parameter int FAST_LAT_CYC = `FPD_FAST_LAT_NS / `FPD_CLK_NS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // straps and configuration
  input wire logic map_format_select,
  input wire logic [1:0] img_len_sel,
  input wire logic large_rating,
  // output image from the master
  input wire logic img_out_valid,
  input wire logic img_out_first,
  input wire logic [7:0] img_out_byte,
  output logic img_out_ready,
  // fast commands to the drive
  output logic [15:0] op_cmd,
  output logic [15:0] freq_ref,
  output logic [15:0] aout1,
  output logic [15:0] dout,
  output logic fast_upd,
  output logic fmt_conv,
  // message bytes to the drive
  output logic msg_valid,
  output logic [7:0] msg_data,
  output logic msg_last,
  input wire logic msg_ready,
  // drive monitors
  input wire logic [15:0] drv_status,
  input wire logic [15:0] motor_speed,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] out_current,
  input wire logic [15:0] torque_mon,
  input wire logic [15:0] fref_mon,
  input wire logic [15:0] ain1,
  input wire logic vf_mode,
  // message replies from the drive
  input wire logic rsp_we,
  input wire logic [3:0] rsp_idx,
  input wire logic [7:0] rsp_data,
  // input image to the master
  input wire logic img_in_req,
  output logic img_in_valid,
  output logic [7:0] img_in_byte,
  output logic img_in_last,
  input wire logic img_in_ready
);
  initial begin
    if (FIFO_DEPTH < 16 || FAST_LAT_CYC < 4)
      $error("fpd_mapper: FIFO_DEPTH >= 16 and FAST_LAT_CYC >= 4 needed");
  end

  ////////////////////////////////////////////////////////////////////////
  // map format, caught once after reset release
  logic fmt_reg, fmt_next, fmt_done_reg, fmt_done_next;
  always_comb begin
    fmt_done_next = 1'b1;
    fmt_next = fmt_done_reg ? fmt_reg : map_format_select;
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fmt_reg <= 1'b0;
      fmt_done_reg <= 1'b0;
    end else begin
      fmt_reg <= fmt_next;
      fmt_done_reg <= fmt_done_next;
    end
  end
  logic conv;
  assign conv = fmt_done_reg && fmt_reg == `FPD_FMT_CONV;

  // length of an image from the selection code
  function automatic logic [5:0] img_len(input logic [1:0] sel);
    logic [5:0] n;
    n = `FPD_LEN_BASIC;
    if (sel == FPD_IMG_EXT1) n = `FPD_LEN_EXT1;
    else if (sel == FPD_IMG_EXT2) n = `FPD_LEN_EXT2;
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // output image receiver
  logic [5:0] rx_idx_reg, rx_idx_next, rx_len_reg, rx_len_next;
  logic [15:0] op_sh_reg, op_sh_next, fr_sh_reg, fr_sh_next;
  logic [15:0] ao_sh_reg, ao_sh_next, do_sh_reg, do_sh_next;
  logic [15:0] op_reg, op_next, fr_reg, fr_next;
  logic [15:0] ao_reg, ao_next, do_reg, do_next;
  logic upd_reg, upd_next;
  logic take, last, push, in_msg, rsv, fifo_rdy;
  logic [5:0] idx, len, mbase;
  logic [5:0] wrd;
  assign take = img_out_valid && fifo_rdy;
  assign idx = img_out_first ? 6'h00 : rx_idx_reg;
  assign len = img_out_first ? img_len(img_len_sel) : rx_len_reg;
  assign last = idx == 6'(len - 6'h01);
  assign wrd = {idx[5:1], 1'b0};
  assign mbase = (len == `FPD_LEN_EXT1) ? `FPD_MSG_EXT1 : `FPD_MSG_EXT2;
  assign in_msg = len != `FPD_LEN_BASIC && idx >= mbase;
  assign rsv = (len == `FPD_LEN_EXT1 && idx >= `FPD_RSV1_LO
    && idx <= `FPD_RSV1_HI)
    || (len == `FPD_LEN_EXT2 && idx == `FPD_RSV2);
  assign push = take && conv && in_msg && !rsv;
  // shadows gather bytes so a torn frame never reaches the drive
  always_comb begin
    rx_idx_next = rx_idx_reg;
    rx_len_next = rx_len_reg;
    op_sh_next = op_sh_reg;
    fr_sh_next = fr_sh_reg;
    ao_sh_next = ao_sh_reg;
    do_sh_next = do_sh_reg;
    op_next = op_reg;
    fr_next = fr_reg;
    ao_next = ao_reg;
    do_next = do_reg;
    upd_next = 1'b0;
    if (take) begin
      rx_idx_next = last ? 6'h00 : 6'(idx + 6'h01);
      rx_len_next = len;
      if (conv && !in_msg) begin
        // high byte sits at the even offset
        if (wrd == `FPD_O_OPCMD) op_sh_next = idx[0] ?
          {op_sh_reg[15:8], img_out_byte} : {img_out_byte, op_sh_reg[7:0]};
        if (wrd == `FPD_O_FREF) fr_sh_next = idx[0] ?
          {fr_sh_reg[15:8], img_out_byte} : {img_out_byte, fr_sh_reg[7:0]};
        if (len == `FPD_LEN_EXT1 && wrd == `FPD_O_AOUT)
          ao_sh_next = idx[0] ? {ao_sh_reg[15:8], img_out_byte}
            : {img_out_byte, ao_sh_reg[7:0]};
        if (len == `FPD_LEN_EXT1 && wrd == `FPD_O_DOUT)
          do_sh_next = idx[0] ? {do_sh_reg[15:8], img_out_byte}
            : {img_out_byte, do_sh_reg[7:0]};
      end
      if (last && conv) begin
        op_next = op_sh_next;
        fr_next = fr_sh_next;
        ao_next = ao_sh_next;
        do_next = do_sh_next;
        upd_next = 1'b1;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_idx_reg <= 6'h00;
      rx_len_reg <= `FPD_LEN_BASIC;
      op_sh_reg <= 16'h0000;
      fr_sh_reg <= 16'h0000;
      ao_sh_reg <= 16'h0000;
      do_sh_reg <= 16'h0000;
      op_reg <= 16'h0000;
      fr_reg <= 16'h0000;
      ao_reg <= 16'h0000;
      do_reg <= 16'h0000;
      upd_reg <= 1'b0;
    end else begin
      rx_idx_reg <= rx_idx_next;
      rx_len_reg <= rx_len_next;
      op_sh_reg <= op_sh_next;
      fr_sh_reg <= fr_sh_next;
      ao_sh_reg <= ao_sh_next;
      do_sh_reg <= do_sh_next;
      op_reg <= op_next;
      fr_reg <= fr_next;
      ao_reg <= ao_next;
      do_reg <= do_next;
      upd_reg <= upd_next;
    end
  end
  assign op_cmd = op_reg;
  assign freq_ref = fr_reg;
  assign aout1 = ao_reg;
  assign dout = do_reg;
  assign fast_upd = upd_reg;
  assign fmt_conv = fmt_reg;
  assign img_out_ready = fifo_rdy;

  ////////////////////////////////////////////////////////////////////////
  // message path; a full buffer stalls the whole output image
  logic f_valid, f_pop;
  logic [8:0] f_data;
  logic mv_reg, mv_next, ml_reg, ml_next;
  logic [7:0] md_reg, md_next;
  fpd_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .reset(reset),
    .in_valid(push),
    .in_data({last, img_out_byte}),
    .in_ready(fifo_rdy),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(f_pop)
  );
  // output stage keeps msg ports on flops
  assign f_pop = !mv_reg || msg_ready;
  always_comb begin
    mv_next = mv_reg;
    md_next = md_reg;
    ml_next = ml_reg;
    if (f_pop) begin
      mv_next = f_valid;
      md_next = f_data[7:0];
      ml_next = f_data[8];
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mv_reg <= 1'b0;
      md_reg <= 8'h00;
      ml_reg <= 1'b0;
    end else begin
      mv_reg <= mv_next;
      md_reg <= md_next;
      ml_reg <= ml_next;
    end
  end
  assign msg_valid = mv_reg;
  assign msg_data = md_reg;
  assign msg_last = ml_reg;

  ////////////////////////////////////////////////////////////////////////
  // reply bytes, indexed from the start of the message region
  logic [7:0] rsp_reg [16];
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) rsp_reg[i] <= 8'h00;
    end else if (rsp_we) begin
      rsp_reg[rsp_idx] <= rsp_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input image sender
  logic [15:0] speed_w, cur_w;
  assign speed_w = vf_mode ? out_freq : motor_speed;
  // a full divide by 10 is always built; its result is selected only on large ratings
  assign cur_w = large_rating ? out_current / `FPD_CUR_DIV
    : out_current;
  function automatic logic [7:0] in_byte(input logic [5:0] i,
      input logic [5:0] n, input logic [15:0] sp, input logic [15:0] cu);
    logic [15:0] w;
    logic [5:0] k, mb;
    logic [7:0] b;
    w = 16'h0000;
    k = {i[5:1], 1'b0};
    mb = (n == `FPD_LEN_EXT1) ? `FPD_MSG_EXT1 : `FPD_MSG_EXT2;
    if (k == `FPD_I_STAT) w = drv_status;
    else if (k == `FPD_I_SPEED) w = sp;
    else if (n == `FPD_LEN_BASIC && k == `FPD_I_CUR_B) w = cu;
    else if (n == `FPD_LEN_EXT1) begin
      if (k == `FPD_I_TRQ) w = torque_mon;
      else if (k == `FPD_I_FREF) w = fref_mon;
      else if (k == `FPD_I_OFREQ) w = out_freq;
      else if (k == `FPD_I_CUR_X) w = cu;
      else if (k == `FPD_I_AIN) w = ain1;
    end
    b = i[0] ? w[7:0] : w[15:8];
    if (n != `FPD_LEN_BASIC && i >= mb) b = rsp_reg[4'(i - mb)];
    if ((n == `FPD_LEN_EXT1 && i >= `FPD_RSV1_LO && i <= `FPD_RSV1_HI)
        || (n == `FPD_LEN_EXT2 && i == `FPD_RSV2)) b = 8'h00;
    return b;
  endfunction
  fpd_tx_t tx_reg, tx_next;
  logic [5:0] tx_idx_reg, tx_idx_next, tx_len_reg, tx_len_next;
  logic iv_reg, iv_next, il_reg, il_next;
  logic [7:0] ib_reg, ib_next;
  logic [5:0] sel_idx, sel_len;
  assign sel_idx = (tx_reg == FPD_TX_IDLE) ? 6'h00
    : 6'(tx_idx_reg + 6'h01);
  assign sel_len = (tx_reg == FPD_TX_IDLE) ? img_len(img_len_sel)
    : tx_len_reg;
  always_comb begin
    tx_next = tx_reg;
    tx_idx_next = tx_idx_reg;
    tx_len_next = tx_len_reg;
    iv_next = iv_reg;
    ib_next = ib_reg;
    il_next = il_reg;
    unique case (tx_reg)
      FPD_TX_IDLE: begin
        if (img_in_req) begin
          tx_next = FPD_TX_SEND;
          tx_idx_next = 6'h00;
          tx_len_next = sel_len;
          iv_next = 1'b1;
          ib_next = conv ? in_byte(sel_idx, sel_len, speed_w, cur_w)
            : 8'h00;
          il_next = 1'b0;
        end
      end
      FPD_TX_SEND: begin
        if (img_in_ready) begin
          if (il_reg) begin
            tx_next = FPD_TX_IDLE;
            iv_next = 1'b0;
            il_next = 1'b0;
          end else begin
            tx_idx_next = sel_idx;
            ib_next = conv ? in_byte(sel_idx, sel_len, speed_w, cur_w)
              : 8'h00;
            il_next = sel_idx == 6'(sel_len - 6'h01);
          end
        end
      end
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_reg <= FPD_TX_IDLE;
      tx_idx_reg <= 6'h00;
      tx_len_reg <= `FPD_LEN_BASIC;
      iv_reg <= 1'b0;
      ib_reg <= 8'h00;
      il_reg <= 1'b0;
    end else begin
      tx_reg <= tx_next;
      tx_idx_reg <= tx_idx_next;
      tx_len_reg <= tx_len_next;
      iv_reg <= iv_next;
      ib_reg <= ib_next;
      il_reg <= il_next;
    end
  end
  assign img_in_valid = iv_reg;
  assign img_in_byte = ib_reg;
  assign img_in_last = il_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_fast_commit;
    @(posedge core_clk) disable iff (reset)
      take && last && conv |=> fast_upd ##1 !fast_upd;
  endproperty
  a_fast_commit: assert property (p_fast_commit)
    else $error("fast commands not committed after frame end");
  // watches the shadow, since the commit waits for the frame end
  property p_opcmd_order;
    @(posedge core_clk) disable iff (reset)
      take && conv && idx == `FPD_O_OPCMD ##1
      take && wrd == `FPD_O_OPCMD && idx[0] |=>
      op_sh_reg == {$past(img_out_byte, 2), $past(img_out_byte)};
  endproperty
  a_opcmd_order: assert property (p_opcmd_order)
    else $error("operation command byte order wrong");
  property p_fmt_hold;
    @(posedge core_clk) disable iff (reset)
      fmt_done_reg |=> $stable(fmt_conv);
  endproperty
  a_fmt_hold: assert property (p_fmt_hold)
    else $error("map format changed without restart");
  property p_no_msg_basic;
    @(posedge core_clk) disable iff (reset)
      push |-> len != `FPD_LEN_BASIC && idx >= `FPD_MSG_EXT2;
  endproperty
  a_no_msg_basic: assert property (p_no_msg_basic)
    else $error("message byte pushed outside message region");
  property p_no_conv_quiet;
    @(posedge core_clk) disable iff (reset)
      !conv |-> !push && !upd_next;
  endproperty
  a_no_conv_quiet: assert property (p_no_conv_quiet)
    else $error("activity in non conventional format");
  property p_rsv_skip;
    @(posedge core_clk) disable iff (reset)
      push |-> !(len == `FPD_LEN_EXT2 && idx == `FPD_RSV2)
        && !(len == `FPD_LEN_EXT1 && idx >= `FPD_RSV1_LO
        && idx <= `FPD_RSV1_HI);
  endproperty
  a_rsv_skip: assert property (p_rsv_skip)
    else $error("reserved message byte forwarded");
  property p_rsv_zero;
    @(posedge core_clk) disable iff (reset)
      img_in_valid && tx_len_reg == `FPD_LEN_EXT1
      && tx_idx_reg >= `FPD_RSV1_LO && tx_idx_reg <= `FPD_RSV1_HI
      |-> img_in_byte == 8'h00;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("reserved input byte not zero");
  property p_msg_hold;
    @(posedge core_clk) disable iff (reset)
      msg_valid && !msg_ready |=> msg_valid && $stable(msg_data)
        && $stable(msg_last);
  endproperty
  a_msg_hold: assert property (p_msg_hold)
    else $error("message byte dropped under stall");
  property p_in_last;
    @(posedge core_clk) disable iff (reset)
      img_in_valid && img_in_last |-> tx_idx_reg == 6'(tx_len_reg - 6'h01);
  endproperty
  a_in_last: assert property (p_in_last)
    else $error("input image length wrong");
  c_fast: cover property (@(posedge core_clk) disable iff (reset)
    fast_upd);
  c_msg_last: cover property (@(posedge core_clk) disable iff (reset)
    msg_valid && msg_last && msg_ready);
  c_full: cover property (@(posedge core_clk) disable iff (reset)
    img_out_valid && !img_out_ready);
  c_in_done: cover property (@(posedge core_clk) disable iff (reset)
    img_in_valid && img_in_last && img_in_ready);
endmodule
`default_nettype wire

// [dv/fpd_master_mdl.sv]
// fpd_master_mdl: behavioural fieldbus master for the image mapper
// assumes one clock; the bench calls its tasks at edge plus 1 ns
`timescale 1ns/10ps
`default_nettype none
module fpd_master_mdl (
  // clock
  input wire logic core_clk,
  // output image
  output logic [1:0] img_len_sel,
  output logic img_out_valid,
  output logic img_out_first,
  output logic [7:0] img_out_byte,
  input wire logic img_out_ready,
  // input image
  output logic img_in_req,
  input wire logic img_in_valid,
  input wire logic [7:0] img_in_byte,
  input wire logic img_in_last,
  output logic img_in_ready
);
  logic [7:0] rx[32];
  logic rx_last[32];
  int tmo = 0;
  ////////////////////////////////////////////////////////////////////////////
  // idle levels at time zero
  initial begin
    img_len_sel = 2'h0;
    img_out_valid = 1'b0;
    img_out_first = 1'b0;
    img_out_byte = 8'h5A;
    img_in_req = 1'b0;
    img_in_ready = 1'b0;
  end
  // one output frame; request held until the ready edge
  task automatic send(input logic [1:0] sel, input logic [7:0] base,
                      input int len);
    int n;
    img_len_sel = sel;
    for (int i = 0; i < len; i++) begin
      img_out_valid = 1'b1;
      img_out_first = (i == 0);
      img_out_byte = base + 8'(i);
      n = 0;
      while (img_out_ready !== 1'b1 && n < 400) begin
        @(posedge core_clk);
        #1;
        n++;
      end
      if (n == 400) tmo++;
      @(posedge core_clk);
      #1;
    end
    img_out_valid = 1'b0;
    img_out_first = 1'b0;
    // released bus shows junk, not the last byte
    img_out_byte = ~img_out_byte;
  endtask
  // one input frame; frames never overlap, so replies are paced
  task automatic recv(input logic [1:0] sel, input int len, input int stall);
    int k;
    int n;
    k = 0;
    n = 0;
    img_len_sel = sel;
    img_in_req = 1'b1;
    @(posedge core_clk);
    #1;
    img_in_req = 1'b0;
    while (k < len && n < 400) begin
      // slow master: ready low for the first stall cycles
      img_in_ready = (n >= stall);
      if (img_in_ready && img_in_valid === 1'b1) begin
        rx[k] = img_in_byte;
        rx_last[k] = img_in_last;
        k++;
      end
      @(posedge core_clk);
      #1;
      n++;
    end
    if (k < len) tmo++;
    img_in_ready = 1'b0;
  endtask
endmodule
`default_nettype wire

// [dv/fpd_tb.sv]
// fpd_tb: self-checking bench of the process data image mapper
// assumes fpd_master_mdl on the fieldbus side, bench as drive side
`timescale 1ns/10ps
`default_nettype none
module tb import fpd_pkg::*;;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic map_format_select = 1'b1;
  logic large_rating = 1'b0;
  logic vf_mode = 1'b0;
  logic msg_ready = 1'b1;
  logic rsp_we = 1'b0;
  logic [3:0] rsp_idx = 4'h0;
  logic [7:0] rsp_data = 8'h00;
  logic [15:0] drv_status = 16'h1234;
  logic [15:0] motor_speed = 16'h5678;
  logic [15:0] out_freq = 16'h9ABC;
  logic [15:0] out_current = 16'h0FA0;
  logic [15:0] torque_mon = 16'h1357;
  logic [15:0] fref_mon = 16'h2468;
  logic [15:0] ain1 = 16'hFEDC;
  logic [1:0] img_len_sel;
  logic img_out_valid, img_out_first, img_out_ready, fast_upd, fmt_conv;
  logic [7:0] img_out_byte, msg_data, img_in_byte;
  logic [15:0] op_cmd, freq_ref, aout1, dout;
  logic msg_valid, msg_last, img_in_req, img_in_valid, img_in_last;
  logic img_in_ready;
  logic [8:0] msg_q[$];
  int error_cnt = 0;
  int check_count = 0;
  ////////////////////////////////////////////////////////////////////////////
  always #25 core_clk = ~core_clk;
  fpd_mapper #(.FIFO_DEPTH(16)) dut_u (.core_clk, .reset, .map_format_select,
    .img_len_sel, .large_rating, .img_out_valid, .img_out_first,
    .img_out_byte, .img_out_ready, .op_cmd, .freq_ref, .aout1, .dout,
    .fast_upd, .fmt_conv, .msg_valid, .msg_data, .msg_last, .msg_ready,
    .drv_status, .motor_speed, .out_freq, .out_current, .torque_mon,
    .fref_mon, .ain1, .vf_mode, .rsp_we, .rsp_idx, .rsp_data, .img_in_req,
    .img_in_valid, .img_in_byte, .img_in_last, .img_in_ready);
  fpd_master_mdl m_u (.core_clk, .img_len_sel, .img_out_valid,
    .img_out_first, .img_out_byte, .img_out_ready, .img_in_req,
    .img_in_valid, .img_in_byte, .img_in_last, .img_in_ready);
  // drive side takes message bytes, last flag on top
  always @(posedge core_clk)
    if (msg_valid === 1'b1 && msg_ready) msg_q.push_back({msg_last, msg_data});
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up;
    error_cnt += m_u.tmo;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_reset(input logic fmt);
    map_format_select = fmt;
    reset = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    reset = 1'b0;
    msg_q.delete();
    // format is caught on the first edge after release
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  // reply bytes of the drive, one per message index
  task automatic load_rsp;
    for (int i = 0; i < 16; i++) begin
      rsp_we = 1'b1;
      rsp_idx = 4'(i);
      rsp_data = 8'hC0 + 8'(i);
      @(posedge core_clk);
      #1;
    end
    rsp_we = 1'b0;
  endtask
  // drive stalls while a long and a short frame arrive; fifo must refuse
  task automatic s_fill;
    logic [8:0] xq[$];
    int n;
    n = 0;
    msg_ready = 1'b0;
    fork
      begin
        m_u.send(FPD_IMG_EXT1, 8'h60, 32);
        // one idle edge so valid is never lowered and raised at once
        @(posedge core_clk);
        #1;
        m_u.send(FPD_IMG_EXT2, 8'h80, 12);
      end
    join_none
    while (img_out_ready === 1'b1 && n < 200) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("out_ready", 16'h0, 16'(img_out_ready));
    chk("msg_valid", 16'h1, 16'(msg_valid));
    msg_ready = 1'b1;
    wait fork;
    for (int i = 16; i < 32; i++)
      if (i < 28 || i == 31) xq.push_back({i == 31, 8'h60 + 8'(i)});
    for (int i = 4; i < 12; i++)
      if (i != 10) xq.push_back({i == 11, 8'h80 + 8'(i)});
    n = 0;
    while (msg_q.size() < xq.size() && n < 100) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("msg_count", 16'(xq.size()), 16'(msg_q.size()));
    foreach (xq[i]) chk("msg_byte", 16'(xq[i]), 16'(msg_q[i]));
    chk("op_cmd", 16'h8081, op_cmd);
    chk("freq_ref", 16'h8283, freq_ref);
    chk("aout1", 16'h6A6B, aout1);
    chk("dout", 16'h6E6F, dout);
  endtask
  // basic frame commits in one cycle, reserved bytes touch nothing
  task automatic s_basic;
    m_u.send(FPD_IMG_BASIC, 8'h10, 6);
    chk("fast_upd", 16'h1, 16'(fast_upd));
    chk("op_cmd", 16'h1011, op_cmd);
    chk("freq_ref", 16'h1213, freq_ref);
    chk("aout1", 16'h6A6B, aout1);
    chk("fmt_conv", 16'h1, 16'(fmt_conv));
    @(posedge core_clk);
    #1;
    chk("fast_upd", 16'h0, 16'(fast_upd));
  endtask
  // input frame against the layout worked out here
  task automatic s_input(input logic [1:0] sel, input int len,
                         input logic lr, input logic vf, input int stall,
                         input logic zero);
    logic [15:0] w[8];
    logic [15:0] c;
    logic [7:0] e;
    int f;
    large_rating = lr;
    vf_mode = vf;
    f = (len == 32) ? 16 : (len == 12) ? 4 : 6;
    c = lr ? out_current / 16'h000A : out_current;
    w = '{default: 16'h0};
    w[0] = drv_status;
    w[1] = vf ? out_freq : motor_speed;
    w[2] = c;
    if (len == 32) begin
      w[2] = torque_mon;
      w[4] = fref_mon;
      w[5] = out_freq;
      w[6] = c;
      w[7] = ain1;
    end
    m_u.recv(sel, len, stall);
    for (int i = 0; i < len; i++) begin
      e = (i < f) ? (i[0] ? w[i/2][7:0] : w[i/2][15:8]) : 8'hC0 + 8'(i - f);
      if ((len == 32 && i > 27 && i < 31) || (len == 12 && i == 10) || zero)
        e = 8'h0;
      chk("in_byte", 16'(e), 16'(m_u.rx[i]));
      chk("in_last", 16'(i == len - 1), 16'(m_u.rx_last[i]));
    end
  endtask
  // format strap only counts at reset
  task automatic s_fmt;
    map_format_select = 1'b0;
    m_u.send(FPD_IMG_BASIC, 8'h30, 6);
    chk("op_cmd", 16'h3031, op_cmd);
    chk("fmt_conv", 16'h1, 16'(fmt_conv));
    t_reset(1'b0);
    chk("fmt_conv", 16'h0, 16'(fmt_conv));
    m_u.send(FPD_IMG_EXT1, 8'h20, 32);
    chk("fast_upd", 16'h0, 16'(fast_upd));
    chk("op_cmd", 16'h0, op_cmd);
    chk("msg_count", 16'h0, 16'(msg_q.size()));
    s_input(FPD_IMG_BASIC, 6, 1'b0, 1'b0, 0, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    t_reset(1'b1);
    load_rsp();
    s_fill();
    s_basic();
    s_input(FPD_IMG_BASIC, 6, 1'b0, 1'b0, 0, 1'b0);
    s_input(FPD_IMG_BASIC, 6, 1'b1, 1'b1, 3, 1'b0);
    s_input(FPD_IMG_EXT2, 12, 1'b0, 1'b0, 2, 1'b0);
    s_input(FPD_IMG_EXT1, 32, 1'b1, 1'b0, 0, 1'b0);
    s_fmt();
    wrap_up();
  end
endmodule
`default_nettype wire
